// ==== design/sasx_exec.sv ====
// Execution of power-down, literal subtract and file subtract.
// Assumes a quarter counter advanced here, file data from the register
// file valid in the second quarter, and wake-up handled elsewhere.
// Summary of operation
// - Power-down decodes Q1, idles Q2 and Q3, enters low power in Q4.
// - Literal subtract: constant minus accumulator, result to accumulator.
// - Literal subtract recognised by top bits 11 110x, literal in low byte.
// - Subtracts change only carry, nibble borrow and zero flags.
// - Literal subtract: decode Q1, read Q2, compute Q3, write Q4.
// - Positive result sets carry to one: no borrow.
// - Zero result sets carry and zero flag.
// - Negative result clears carry, wrapped value stored.
// - Destination bit zero writes accumulator, one writes file register.
`timescale 1ns/1ps
module sasx_exec #(
  parameter int W = sasx_pkg::DATA_W
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       srst,
  // Instruction from decoder, held for the whole cycle
  input  wire logic [sasx_pkg::INSN_W-1:0] insn,
  // Register file read port
  output logic [sasx_pkg::FADDR_W-1:0]    file_addr,
  input  wire logic [W-1:0]               file_rdata,
  // Register file write port
  output logic                            file_we,
  output logic [W-1:0]                    file_wdata,
  // Core state
  output logic [W-1:0]                    acc,
  output logic [7:0]                      status,
  output logic [1:0]                      quarter,
  output logic                            sleep_enter,
  output logic                            asleep
);
  typedef enum {SASX_NONE, SASX_SLEEP, SASX_SUBL, SASX_SUBF} sasx_op_t;

  function automatic sasx_op_t sasx_decode(input logic [13:0] i);
    if (i == sasx_pkg::OP_SLEEP) return SASX_SLEEP;
    else if (i[13:9] == sasx_pkg::OP_SUBLIT_HI) return SASX_SUBL;
    else if (i[13:8] == sasx_pkg::OP_SUBFILE_HI) return SASX_SUBF;
    else return SASX_NONE;
  endfunction

  sasx_op_t     op_r, op_nxt;
  logic [1:0]   q_r, q_nxt;
  logic [W-1:0] opa_r, opa_nxt;
  logic [W-1:0] res_r, res_nxt;
  logic         c_r, c_nxt;
  logic         nb_r, nb_nxt;
  logic         z_r, z_nxt;
  logic         dest_r, dest_nxt;
  logic [W-1:0] acc_r, acc_nxt;
  logic [7:0]   st_r, st_nxt;
  logic         we_r, we_nxt;
  logic [W-1:0] wd_r, wd_nxt;
  logic         sleep_r, sleep_nxt;
  logic         pulse_r, pulse_nxt;
  logic [W-1:0] diff;
  logic         cy;
  logic         nbc;
  logic         zz;

  function automatic logic is_sub(input sasx_op_t o);
    return (o == SASX_SUBL) || (o == SASX_SUBF);
  endfunction

  sasx_sub_unit #(
    .W (W)
  ) sasx_sub_unit_inst (
    .op_a     (opa_r),
    .op_b     (acc_r),
    .diff     (diff),
    .carry_nb (cy),
    .nib_nb   (nbc),
    .zero     (zz)
  );

  // Quarter counter: keeps running while asleep
  always_comb begin
    q_nxt = q_r + 2'h1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q_r <= 2'h0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Decode in Q1, operand capture in Q2
  always_comb begin
    op_nxt   = op_r;
    dest_nxt = dest_r;
    opa_nxt  = opa_r;
    case (q_r)
      2'h0: begin
        op_nxt = sasx_decode(insn);
        // Literal form has no destination bit
        if (sasx_decode(insn) == SASX_SUBL) begin
          dest_nxt = sasx_pkg::DEST_ACC;
        end else begin
          dest_nxt = insn[sasx_pkg::DEST_BIT];
        end
      end
      2'h1: begin
        // Power-down does nothing here
        if (op_r == SASX_SUBL) begin
          opa_nxt = insn[sasx_pkg::LIT_LSB +: W];
        end else if (op_r == SASX_SUBF) begin
          opa_nxt = file_rdata;
        end
      end
      2'h3: begin
        op_nxt = SASX_NONE;
      end
      default: begin
        op_nxt = op_r;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      op_r   <= SASX_NONE;
      dest_r <= 1'h0;
      opa_r  <= '0;
    end else begin
      op_r   <= op_nxt;
      dest_r <= dest_nxt;
      opa_r  <= opa_nxt;
    end
  end

  // Process in Q3; flags held aside until the write quarter
  always_comb begin
    res_nxt = res_r;
    c_nxt   = c_r;
    nb_nxt  = nb_r;
    z_nxt   = z_r;
    if (q_r == 2'h2 && is_sub(op_r)) begin
      res_nxt = diff;
      c_nxt   = cy;
      nb_nxt  = nbc;
      z_nxt   = zz;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      res_r <= '0;
      c_r   <= 1'h0;
      nb_r  <= 1'h0;
      z_r   <= 1'h0;
    end else begin
      res_r <= res_nxt;
      c_r   <= c_nxt;
      nb_r  <= nb_nxt;
      z_r   <= z_nxt;
    end
  end

  // Write-back in Q4
  always_comb begin
    acc_nxt = acc_r;
    st_nxt  = st_r;
    we_nxt  = 1'h0;
    wd_nxt  = wd_r;
    if (q_r == 2'h3 && is_sub(op_r)) begin
      // Only the three arithmetic flags move
      st_nxt[sasx_pkg::ST_C]  = c_r;
      st_nxt[sasx_pkg::ST_NB] = nb_r;
      st_nxt[sasx_pkg::ST_Z]  = z_r;
      if (dest_r == sasx_pkg::DEST_ACC) begin
        acc_nxt = res_r;
      end else begin
        we_nxt = 1'h1;
        wd_nxt = res_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_r <= sasx_pkg::ACC_RST;
      st_r  <= sasx_pkg::STATUS_RST;
      we_r  <= 1'h0;
      wd_r  <= '0;
    end else begin
      acc_r <= acc_nxt;
      st_r  <= st_nxt;
      we_r  <= we_nxt;
      wd_r  <= wd_nxt;
    end
  end

  // Power-down takes effect in Q4
  always_comb begin
    sleep_nxt = sleep_r;
    pulse_nxt = 1'h0;
    if (q_r == 2'h3 && op_r == SASX_SLEEP) begin
      sleep_nxt = 1'h1;
      pulse_nxt = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_r <= 1'h0;
      pulse_r <= 1'h0;
    end else begin
      sleep_r <= sleep_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  // Address straight from the held instruction; the file answers in Q2
  assign file_addr   = insn[sasx_pkg::FADDR_LSB +: sasx_pkg::FADDR_W];
  assign file_we     = we_r;
  assign file_wdata  = wd_r;
  assign acc         = acc_r;
  assign status      = st_r;
  assign quarter     = q_r;
  assign sleep_enter = pulse_r;
  // Stays set until reset; wake-up lives outside this block
  assign asleep      = sleep_r;

  // Opcode literal field and flag byte are fixed at eight bits
  if (W != 8) begin : g_width_check
    $error("sasx_exec: data width must be 8");
  end
endmodule // sasx_exec

// ==== design/sasx_pkg.sv ====
// Shared constants for the subtract and sleep execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package sasx_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  // Opcode patterns
  localparam logic [13:0] OP_SLEEP     = 14'h0063;
  localparam logic [4:0]  OP_SUBLIT_HI = 5'h1e;   // 11 110x
  localparam logic [5:0]  OP_SUBFILE_HI = 6'h02;  // 00 0010
  // Instruction fields
  localparam int LIT_LSB   = 0;
  localparam int DEST_BIT  = 7;
  localparam int FADDR_LSB = 0;
  // Status bit positions inside the flag byte
  localparam int ST_C  = 0;
  localparam int ST_NB = 1;
  localparam int ST_Z  = 2;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic       DEST_ACC   = 1'b0;
  localparam int QUARTERS = 4;
endpackage : sasx_pkg

// ==== design/sasx_sub_unit.sv ====
// Pure subtractor: a minus b with no-borrow flags.
// Assumes callers register the outputs.
`timescale 1ns/1ps
module sasx_sub_unit #(
  parameter int W = 8
) (
  // Operands
  input  wire logic [W-1:0] op_a,
  input  wire logic [W-1:0] op_b,
  // Results
  output logic [W-1:0]      diff,
  output logic              carry_nb,
  output logic              nib_nb,
  output logic              zero
);
  logic [W:0] full;
  logic [4:0] low;
  always_comb begin
    // Two's complement: a + ~b + 1, carry out means no borrow
    full     = {1'b0, op_a} + {1'b0, ~op_b} + {{W{1'b0}}, 1'b1};
    low      = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + 5'h01;
    diff     = full[W-1:0];
    carry_nb = full[W];
    nib_nb   = low[4];
    zero     = (full[W-1:0] == '0);
  end
  // Nibble flag needs bits 3:0 plus a carry into bit 4
  if (W < 5) begin : g_width_check
    $error("sasx_sub_unit: width too small");
  end
endmodule // sasx_sub_unit

// ==== testbench/sasx_exec_props.sv ====
// Checker for the subtract and sleep block, bound to its ports.
// Assumes instructions aligned to quarter zero, four clocks each.
`timescale 1ns/1ps
module sasx_exec_props #(parameter int W = 8) (
  // Clock and reset
  input wire logic         clk,
  input wire logic         srst,
  // Watched ports
  input wire logic [13:0]  insn,
  input wire logic [W-1:0] file_rdata,
  input wire logic         file_we,
  input wire logic [W-1:0] file_wdata,
  input wire logic [W-1:0] acc,
  input wire logic [7:0]   status,
  input wire logic [1:0]   quarter,
  input wire logic         sleep_enter,
  input wire logic         asleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // No reset since the decode edge four clocks back
  sequence s_done;
    quarter == 2'h0 && $past(quarter) == 2'h3 && !$past(srst)
      && !$past(srst, 4);
  endsequence
  sequence s_lit;
    s_done ##0 $past(insn[13:9], 4) == sasx_pkg::OP_SUBLIT_HI;
  endsequence
  sequence s_file;
    s_done ##0 $past(insn[13:8], 4) == sasx_pkg::OP_SUBFILE_HI;
  endsequence
  a_acc_slot: assert property (!$stable(acc) |-> $past(quarter) == 2'h3)
    else $error("acc changed outside the write quarter");
  a_lit_result: assert property (s_lit |-> acc == $past(insn[7:0], 4) - $past(acc, 4))
    else $error("literal subtract result wrong");
  a_lit_flags: assert property (s_lit |-> status[1:0] == {$past(insn[3:0], 4) >= $past(acc[3:0], 4), $past(insn[7:0], 4) >= $past(acc, 4)})
    else $error("literal subtract borrow flags wrong");
  a_lit_zero: assert property (s_lit |-> status[2] == (acc == 8'h00))
    else $error("zero flag wrong");
  a_file_dest: assert property (s_file |-> file_we == $past(insn[7], 4))
    else $error("file subtract destination wrong");
  a_file_data: assert property (s_file ##0 file_we |-> file_wdata == $past(file_rdata, 3) - $past(acc, 4) && $stable(acc))
    else $error("file subtract write data wrong");
  a_flags_only: assert property (!$stable(status) |-> $past(quarter) == 2'h3 && status[7:3] == sasx_pkg::STATUS_RST[7:3])
    else $error("status changed outside its flags");
  a_sleep_pulse: assert property (sleep_enter |-> ($past(quarter) == 2'h3 && $past(insn, 4) == sasx_pkg::OP_SLEEP) ##1 !sleep_enter)
    else $error("power-down entry badly timed");
  a_sleep_level: assert property ($rose(asleep) |-> sleep_enter)
    else $error("asleep rose without entry");
endmodule // sasx_exec_props

// ==== testbench/sasx_exec_test.sv ====
// Self-checking bench for the subtract and sleep block.
// Assumes four-quarter timing; inputs change at falling edges.
`timescale 1ns/1ps
module sasx_exec_test;
  logic        clk = 1'b0, srst = 1'b1, we, slp, asl;
  logic [13:0] insn = 14'h0000;
  logic [7:0]  rd = 8'h00, lf = 8'h3b, k, m_acc = 8'h00, m_st = 8'h18;
  logic [7:0]  wd, acc, st;
  logic [6:0]  fa;
  logic [1:0]  qt;
  int          miscompares = 0, cmp_count = 0;
  always #20 clk = ~clk;
  sasx_exec sasx_exec_inst (.clk(clk), .srst(srst), .insn(insn),
    .file_addr(fa), .file_rdata(rd), .file_we(we), .file_wdata(wd),
    .acc(acc), .status(st), .quarter(qt), .sleep_enter(slp), .asleep(asl));
  function automatic logic [7:0] nxt(logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One instruction: model first, then compare after its fourth quarter
  task automatic run(logic [13:0] i, logic [7:0] f);
    logic [7:0] a, r;
    logic       lit, sub, d;
    insn = i;
    rd = f;
    lit = i[13:9] == sasx_pkg::OP_SUBLIT_HI;
    sub = i[13:8] == sasx_pkg::OP_SUBFILE_HI;
    d = sub && i[7];
    a = lit ? i[7:0] : f;
    r = a - m_acc;
    if (lit || sub) begin
      m_st[2:0] = {r == 8'h00, a[3:0] >= m_acc[3:0], a >= m_acc};
      if (!d) m_acc = r;
    end
    repeat (4) @(negedge clk);
    chk("file_addr", {1'b0, fa}, {1'b0, i[6:0]});
    chk("quarter", {6'h00, qt}, 8'h00);
    chk("acc", acc, m_acc);
    chk("status", st, m_st);
    chk("file_we", {7'h00, we}, {7'h00, d});
    if (d) chk("file_wdata", wd, r);
    chk("sleep_enter", {7'h00, slp}, {7'h00, i == sasx_pkg::OP_SLEEP});
  endtask
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    run(14'h3c00, 8'h00);
    run(14'h3d05, 8'h00);
    run(14'h3c02, 8'h00);
    run(14'h0000, 8'h77);
    run(14'h0283, 8'h09);
    run(14'h0205, 8'h40);
    repeat (60) begin
      lf = nxt(lf);
      k = lf;
      lf = nxt(lf);
      run(lf[7] ? {5'h1e, lf[6], k} : {6'h02, k}, lf);
    end
    run(sasx_pkg::OP_SLEEP, 8'h00);
    repeat (3) @(negedge clk);
    chk("asleep", {7'h00, asl}, 8'h01);
    end_of_test();
  end
  initial begin
    #30000;
    miscompares++;
    end_of_test();
  end
endmodule // sasx_exec_test
bind sasx_exec sasx_exec_props #(.W(W)) sasx_exec_props_inst (.clk(clk),
  .srst(srst), .insn(insn), .file_rdata(file_rdata), .file_we(file_we),
  .file_wdata(file_wdata), .acc(acc), .status(status), .quarter(quarter),
  .sleep_enter(sleep_enter), .asleep(asleep));
